// File: rtl/lpmc_ctrl.sv
// low power operating mode controller with avalon-mm register slave
// Summary of operation
// - periph halts stop cpu and watchdog only
// - halts freeze memory, registers, psw, port latches
// - halted pc holds request address plus two
// - periph halt release clears request, restores run
// - reset pin low releases; restart fast_only_run
// - master off: enabled latch wakes, no vector
// - master on: enabled latch wakes and services
// - pending watchdog interrupt cancels halt entry
// - timebase halts clock only the timebase timer
// - timebase halt release clears request, restores run
// - timebase enabled at entry sets timebase latch
// - timebase halt ignores timebase_enable for entry/release
// - and-term zero: source falling edge wakes, no irq
// - and-term one: source falling edge wakes, services
// - timebase halt may be shorter than period
// - illegal oscillator disable applies system reset
`timescale 1ns/10ps
module lpmc_ctrl
  import lpmc_pkg::*;
#(
  parameter int NUM_IRQ = 8,
  parameter int PC_W = 16
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu side
  input wire logic [PC_W-1:0] cpu_halt_pc,
  input wire logic [NUM_IRQ-1:0] irq_latch,
  input wire logic [NUM_IRQ-1:0] irq_latch_clear,
  input wire logic reset_pin_n,
  input wire logic [7:0] timebase_sources,
  output logic cpu_clk_en,
  output logic wdt_clk_en,
  output logic periph_clk_en,
  output logic timebase_clk_en,
  output logic state_hold,
  output logic [PC_W-1:0] resume_pc,
  output logic irq_service_req,
  output logic [NUM_IRQ-1:0] irq_latch_set,
  output logic fast_osc_enable,
  output logic slow_osc_enable,
  output logic main_clock_select,
  output logic clock_fault_reset
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  // the timebase latch index and the master enable bit fix the flag count
  if (NUM_IRQ < 7 || NUM_IRQ > 8) begin : g_bad_irq
    $error("NUM_IRQ must be 7 or 8");
  end
  if (PC_W < 2 || PC_W > 16) begin : g_bad_pc
    $error("PC_W must be 2..16");
  end

  // ----------------------------------------
  // input synchronisers for pin sourced levels
  // ----------------------------------------
  logic [1:0] rstp_q;
  logic [7:0] tbs1_q, tbs2_q;
  logic tb_prev_q;
  always_ff @(posedge mclk) begin
    if (rst) begin
      rstp_q <= 2'h3;
      tbs1_q <= 8'h00;
      tbs2_q <= 8'h00;
    end else begin
      // the reset pin must act even while the block is frozen
      rstp_q <= {rstp_q[0], reset_pin_n};
      if (clk_en) begin
        tbs1_q <= timebase_sources;
        tbs2_q <= tbs1_q;
      end
    end
  end
  wire pin_reset = ~rstp_q[1];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] sys_q, tbc_q;
  logic [NUM_IRQ-1:0] ief_q;
  logic master_q;
  lpmc_state_t state_q, state_d;
  lpmc_run_t run_mode;
  logic [PC_W-1:0] pc_q;
  logic fault_q;

  wire fast_en = sys_q[LPMC_FAST_OSC_BIT];
  wire slow_en = sys_q[LPMC_SLOW_OSC_BIT];
  wire clk_sel = sys_q[LPMC_CLK_SEL_BIT];
  wire tb_en = tbc_q[LPMC_TB_EN_BIT];
  wire [LPMC_TB_SEL_W-1:0] tb_sel = tbc_q[LPMC_TB_SEL_LSB +: LPMC_TB_SEL_W];

  // ----------------------------------------
  // bus decode: one wait state on every access
  // ----------------------------------------
  logic ack_q;
  wire req = (avs_read | avs_write) & clk_en;
  // ack only counts on an enabled edge, so a frozen cycle never drops a write
  wire ack_now = ack_q & clk_en;
  wire wr_go = avs_write & ack_now;
  wire wr_sys = wr_go & (avs_address == LPMC_SYS_CTRL_OFS);
  wire wr_tbc = wr_go & (avs_address == LPMC_TB_CTRL_OFS);
  wire wr_ief = wr_go & (avs_address == LPMC_IRQ_EN_OFS);
  assign avs_waitrequest = ~ack_now;
  always_ff @(posedge mclk) begin
    if (rst) ack_q <= 1'b0;
    else if (clk_en) ack_q <= req & ~ack_q;
  end

  wire [31:0] rd_mux =
    (avs_address == LPMC_SYS_CTRL_OFS) ? {24'h0, sys_q} :
    (avs_address == LPMC_TB_CTRL_OFS) ? {24'h0, tbc_q} :
    (avs_address == LPMC_IRQ_EN_OFS) ? {23'h0, master_q, 8'(ief_q)} :
    (avs_address == LPMC_STATUS_OFS) ? {24'h0, 2'(run_mode), 3'(state_q), irq_latch[2:0]} :
    LPMC_ZERO;
  always_ff @(posedge mclk) begin
    if (rst) avs_readdata <= LPMC_ZERO;
    else if (clk_en && req && !ack_q) avs_readdata <= rd_mux;
  end

  // ----------------------------------------
  // wake and entry decisions
  // ----------------------------------------
  wire halted = (state_q != LPMC_RUN);
  wire irq_wake = |(irq_latch & ief_q);
  wire tb_now = tbs2_q[tb_sel];
  wire tb_fall = tb_prev_q & ~tb_now;
  wire tb_and = master_q & ief_q[LPMC_TB_IRQ_IDX] & tb_en;
  wire wdt_pend = irq_latch[LPMC_WDT_IRQ_IDX];
  wire new_cpu_halt = wr_sys & avs_writedata[LPMC_CPU_HALT_BIT];
  wire new_gen_halt = wr_sys & avs_writedata[LPMC_GEN_HALT_BIT];
  // a pending watchdog interrupt wins over entry; both-at-once is ignored
  wire enter_ok = ~halted & ~wdt_pend & ~(new_cpu_halt & new_gen_halt);
  wire periph_halt = (state_q == LPMC_PERIPH_FAST_HALT) | (state_q == LPMC_PERIPH_SLOW_HALT);
  wire tb_halt = (state_q == LPMC_TB_FAST_HALT) | (state_q == LPMC_TB_SLOW_HALT);
  wire release_p = periph_halt & irq_wake;
  wire release_t = tb_halt & tb_fall;

  always_comb begin
    state_d = state_q;
    if (release_p || release_t) begin
      state_d = LPMC_RUN;
    end else if (enter_ok && new_cpu_halt) begin
      state_d = clk_sel ? LPMC_PERIPH_SLOW_HALT : LPMC_PERIPH_FAST_HALT;
    end else if (enter_ok && new_gen_halt) begin
      state_d = clk_sel ? LPMC_TB_SLOW_HALT : LPMC_TB_FAST_HALT;
    end
  end

  // illegal oscillator combination after a write
  wire [7:0] sys_w = avs_writedata[7:0];
  wire bad_osc = wr_sys & ((~sys_w[LPMC_FAST_OSC_BIT] & ~sys_w[LPMC_SLOW_OSC_BIT]) |
    (~sys_w[LPMC_FAST_OSC_BIT] & ~sys_w[LPMC_CLK_SEL_BIT]) |
    (~sys_w[LPMC_SLOW_OSC_BIT] & sys_w[LPMC_CLK_SEL_BIT]));

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (rst || pin_reset) begin
      state_q <= LPMC_RUN;
      sys_q <= LPMC_SYS_CTRL_RST;
      tbc_q <= LPMC_TB_CTRL_RST;
      ief_q <= '0;
      master_q <= 1'b0;
      pc_q <= '0;
      tb_prev_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (clk_en) begin
      state_q <= state_d;
      tb_prev_q <= tb_now;
      fault_q <= bad_osc;
      if (wr_sys) begin
        sys_q <= sys_w & ~(8'h1 << LPMC_CPU_HALT_BIT) & ~(8'h1 << LPMC_GEN_HALT_BIT);
        if (state_d != LPMC_RUN) begin
          sys_q[LPMC_CPU_HALT_BIT] <= new_cpu_halt;
          sys_q[LPMC_GEN_HALT_BIT] <= new_gen_halt;
        end
      end else if (release_p || release_t) begin
        sys_q[LPMC_CPU_HALT_BIT] <= 1'b0;
        sys_q[LPMC_GEN_HALT_BIT] <= 1'b0;
      end
      if (wr_tbc) tbc_q <= avs_writedata[7:0];
      if (wr_ief) begin
        ief_q <= avs_writedata[NUM_IRQ-1:0];
        master_q <= avs_writedata[LPMC_MASTER_EN_BIT];
      end
      if (!halted && state_d != LPMC_RUN) pc_q <= cpu_halt_pc + PC_W'(LPMC_PC_STEP);
    end
  end

  // mode tracking: run_mode is the mode the halt returns to
  always_comb begin
    if (clk_sel) run_mode = fast_en ? LPMC_SLOW_DUAL_RUN : LPMC_SLOW_ONLY_RUN;
    else run_mode = slow_en ? LPMC_FAST_DUAL_RUN : LPMC_FAST_ONLY_RUN;
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign cpu_clk_en = ~halted;
  assign wdt_clk_en = ~halted;
  assign periph_clk_en = ~tb_halt;
  assign timebase_clk_en = 1'b1;
  assign state_hold = halted;
  assign resume_pc = pc_q;
  // service only when master enable is on; otherwise execution just continues
  assign irq_service_req = ((release_p & master_q) | (release_t & tb_and)) & clk_en;
  // latch set on timebase-halt entry when the timebase is enabled
  generate
    for (genvar i = 0; i < NUM_IRQ; i++) begin : g_set
      if (i == LPMC_TB_IRQ_IDX) begin : g_tb
        assign irq_latch_set[i] = ~halted & (state_d == LPMC_TB_FAST_HALT ||
          state_d == LPMC_TB_SLOW_HALT) & tb_en & clk_en;
      end else begin : g_no
        assign irq_latch_set[i] = 1'b0;
      end
    end
  endgenerate
  assign fast_osc_enable = fast_en;
  assign slow_osc_enable = slow_en;
  assign main_clock_select = clk_sel;
  assign clock_fault_reset = fault_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  wire any_rst = rst | pin_reset;
  sequence s_p_release;
    periph_halt && irq_wake && clk_en;
  endsequence
  sequence s_t_release;
    tb_halt && tb_fall && clk_en;
  endsequence
  // exactly one halt bit written while running and nothing blocking it
  sequence s_entry;
    enter_ok && clk_en && (new_cpu_halt ^ new_gen_halt);
  endsequence
  a_periph_wake_run: assert property (@(posedge mclk) disable iff (any_rst)
    s_p_release |=> (state_q == LPMC_RUN && !sys_q[LPMC_CPU_HALT_BIT]))
    else $error("periph halt not released");
  a_periph_mode_kept: assert property (@(posedge mclk) disable iff (any_rst)
    (s_p_release ##0 !wr_sys) |=> run_mode == $past(run_mode))
    else $error("run mode lost on periph release");
  a_tb_wake_run: assert property (@(posedge mclk) disable iff (any_rst)
    s_t_release |=> (state_q == LPMC_RUN && !sys_q[LPMC_GEN_HALT_BIT]))
    else $error("timebase halt not released");
  a_tb_mode_kept: assert property (@(posedge mclk) disable iff (any_rst)
    (s_t_release ##0 !wr_sys) |=> run_mode == $past(run_mode))
    else $error("run mode lost on timebase release");
  a_cpu_stopped: assert property (@(posedge mclk) disable iff (rst)
    periph_halt |-> (!cpu_clk_en && !wdt_clk_en && periph_clk_en))
    else $error("cpu clock in periph halt");
  a_tb_clk_only: assert property (@(posedge mclk) disable iff (rst)
    tb_halt |-> (!periph_clk_en && timebase_clk_en))
    else $error("peripheral clock in tb halt");
  a_pc_plus_two: assert property (@(posedge mclk) disable iff (any_rst)
    s_entry |=> resume_pc == $past(cpu_halt_pc) + PC_W'(LPMC_PC_STEP))
    else $error("resume pc wrong");
  a_pc_held: assert property (@(posedge mclk) disable iff (any_rst)
    (halted && $past(halted)) |-> $stable(resume_pc))
    else $error("resume pc moved while halted");
  a_wdt_blocks: assert property (@(posedge mclk) disable iff (any_rst)
    (!halted && wdt_pend && clk_en && (new_cpu_halt || new_gen_halt)) |=> state_q == LPMC_RUN)
    else $error("halt entered over watchdog");
  a_both_halts: assert property (@(posedge mclk) disable iff (any_rst)
    (!halted && clk_en && new_cpu_halt && new_gen_halt) |=> state_q == LPMC_RUN)
    else $error("halt entered on double request");
  a_reset_run: assert property (@(posedge mclk) disable iff (rst)
    pin_reset |=> state_q == LPMC_RUN)
    else $error("reset did not release halt");
  a_clk_variant: assert property (@(posedge mclk) disable iff (any_rst)
    (s_entry ##0 new_cpu_halt)
    |=> state_q == ($past(clk_sel) ? LPMC_PERIPH_SLOW_HALT : LPMC_PERIPH_FAST_HALT))
    else $error("wrong periph halt variant");
  a_tb_variant: assert property (@(posedge mclk) disable iff (any_rst)
    (s_entry ##0 new_gen_halt)
    |=> state_q == ($past(clk_sel) ? LPMC_TB_SLOW_HALT : LPMC_TB_FAST_HALT))
    else $error("wrong timebase halt variant");
  a_tb_entry_any: assert property (@(posedge mclk) disable iff (any_rst)
    (s_entry ##0 new_gen_halt) |=> tb_halt)
    else $error("timebase halt not entered");
  a_no_vector: assert property (@(posedge mclk) disable iff (any_rst)
    (s_p_release ##0 !master_q) |-> !irq_service_req)
    else $error("vector without master enable");
  a_vector: assert property (@(posedge mclk) disable iff (any_rst)
    (s_p_release ##0 master_q) |-> irq_service_req)
    else $error("no vector with master enable");
  a_tb_no_irq: assert property (@(posedge mclk) disable iff (any_rst)
    (s_t_release ##0 !tb_and) |-> !irq_service_req)
    else $error("timebase vector with and-term zero");
  a_tb_irq: assert property (@(posedge mclk) disable iff (any_rst)
    (s_t_release ##0 tb_and) |-> irq_service_req)
    else $error("no timebase vector with and-term one");
  a_tb_latch_set: assert property (@(posedge mclk) disable iff (any_rst)
    (s_entry ##0 (new_gen_halt && tb_en)) |-> irq_latch_set[LPMC_TB_IRQ_IDX])
    else $error("timebase latch not set");
  a_tb_latch_quiet: assert property (@(posedge mclk) disable iff (any_rst)
    !tb_en |-> !irq_latch_set[LPMC_TB_IRQ_IDX])
    else $error("timebase latch set while disabled");
  a_osc_fault: assert property (@(posedge mclk) disable iff (any_rst)
    (clk_en && bad_osc) |=> clock_fault_reset)
    else $error("oscillator fault missed");
  a_osc_quiet: assert property (@(posedge mclk) disable iff (any_rst)
    !(clk_en && bad_osc) |=> !clock_fault_reset)
    else $error("oscillator fault without cause");
endmodule

// File: rtl/lpmc_pkg.sv
// package of constants and types for the low power mode controller
package lpmc_pkg;
  // ----------------------------------------
  // register map (offsets are byte addresses, compared directly with avs_address)
  // ----------------------------------------
  localparam logic [3:0] LPMC_SYS_CTRL_OFS = 4'h0;
  localparam logic [3:0] LPMC_TB_CTRL_OFS = 4'h4;
  localparam logic [3:0] LPMC_IRQ_EN_OFS = 4'h8;
  localparam logic [3:0] LPMC_STATUS_OFS = 4'hc;
  // ----------------------------------------
  // system_control_two fields
  // ----------------------------------------
  localparam int LPMC_FAST_OSC_BIT = 7;
  localparam int LPMC_SLOW_OSC_BIT = 6;
  localparam int LPMC_CLK_SEL_BIT = 5;
  localparam int LPMC_CPU_HALT_BIT = 4;
  localparam int LPMC_GEN_HALT_BIT = 2;
  localparam logic [7:0] LPMC_SYS_CTRL_RST = 8'h80;
  // ----------------------------------------
  // timebase_control fields
  // ----------------------------------------
  localparam int LPMC_TB_EN_BIT = 3;
  localparam int LPMC_TB_SEL_LSB = 0;
  localparam int LPMC_TB_SEL_W = 3;
  localparam logic [7:0] LPMC_TB_CTRL_RST = 8'h00;
  // ----------------------------------------
  // interrupt fields
  // ----------------------------------------
  localparam int LPMC_TB_IRQ_IDX = 6;
  localparam int LPMC_WDT_IRQ_IDX = 0;
  localparam int LPMC_MASTER_EN_BIT = 8;
  localparam logic [31:0] LPMC_ZERO = 32'h0;
  // halted pc points this many bytes past the halt request instruction
  localparam int LPMC_PC_STEP = 2;
  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    LPMC_FAST_ONLY_RUN,
    LPMC_FAST_DUAL_RUN,
    LPMC_SLOW_DUAL_RUN,
    LPMC_SLOW_ONLY_RUN
  } lpmc_run_t;
  typedef enum logic [2:0] {
    LPMC_RUN,
    LPMC_PERIPH_FAST_HALT,
    LPMC_PERIPH_SLOW_HALT,
    LPMC_TB_FAST_HALT,
    LPMC_TB_SLOW_HALT
  } lpmc_state_t;
endpackage

// File: verification/tb_top.sv
// self-checking testbench for the low power mode controller
`timescale 1ns/10ps
module tb_top;
  import lpmc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] cpu_halt_pc = 16'h0;
  logic [7:0] irq_latch = 8'h00;
  logic [7:0] irq_latch_clear = 8'h00;
  logic reset_pin_n = 1'b1;
  logic [7:0] timebase_sources = 8'hff;
  logic cpu_clk_en, wdt_clk_en, periph_clk_en, timebase_clk_en, state_hold, irq_service_req;
  logic fast_osc_enable, slow_osc_enable, main_clock_select, clock_fault_reset;
  logic [15:0] resume_pc;
  logic [7:0] irq_latch_set, sysval;
  logic [31:0] rd;
  logic [7:0] bad [3] = '{8'h00, 8'h40, 8'ha0};
  int err_count = 0;
  int samples_checked = 0;
  int seed = 81024;
  int cycles = 0;
  int svc = 0;
  int setc = 0;
  int flt = 0;
  int i, src, s0, s1;
  logic mst;

  lpmc_ctrl lpmc_ctrl_inst (.mclk, .rst, .clk_en, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .cpu_halt_pc, .irq_latch,
    .irq_latch_clear, .reset_pin_n, .timebase_sources, .cpu_clk_en, .wdt_clk_en,
    .periph_clk_en, .timebase_clk_en, .state_hold, .resume_pc, .irq_service_req,
    .irq_latch_set, .fast_osc_enable, .slow_osc_enable, .main_clock_select,
    .clock_fault_reset);

  always #5 mclk = ~mclk;

  // ----------------------------------------
  // pulse counters and timeout
  // ----------------------------------------
  // one-cycle pulses are counted here so no scenario can miss them
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (irq_service_req === 1'b1) svc <= svc + 1;
    if (irq_latch_set[LPMC_TB_IRQ_IDX] === 1'b1) setc <= setc + 1;
    if (clock_fault_reset === 1'b1) flt <= flt + 1;
    if (cycles > 5000) begin
      err_count = err_count + 1;
      results();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // called at a rising edge; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 40);
    rd = avs_readdata;
    if (k >= 40) err_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic wait_wake(input int lim);
    int k;
    k = 0;
    while (cpu_clk_en !== 1'b1 && k < lim) begin
      @(posedge mclk);
      k++;
    end
    chk({31'h0, cpu_clk_en}, 32'h1);
    repeat (2) @(posedge mclk);
  endtask
  task automatic rst_pulse();
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    sysval = 8'h80;
  endtask
  function automatic logic [31:0] stat(input logic [1:0] run, input logic [2:0] st);
    return {24'h0, run, st, irq_latch[2:0]};
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    rdchk(LPMC_SYS_CTRL_OFS, {24'h0, LPMC_SYS_CTRL_RST});
    rdchk(LPMC_TB_CTRL_OFS, 32'h0);
    rdchk(LPMC_IRQ_EN_OFS, 32'h0);
    rdchk(LPMC_STATUS_OFS, stat(2'd0, 3'd0));
    rdchk(4'h2, 32'h0);
    sysval = 8'h80;
    for (i = 0; i < 8; i++) begin
      if (i == 4) begin
        bus(1'b1, LPMC_SYS_CTRL_OFS, 32'hc0);
        rdchk(LPMC_STATUS_OFS, stat(2'd1, 3'd0));
        bus(1'b1, LPMC_SYS_CTRL_OFS, 32'he0);
        rdchk(LPMC_STATUS_OFS, stat(2'd2, 3'd0));
        bus(1'b1, LPMC_SYS_CTRL_OFS, 32'h60);
        rdchk(LPMC_STATUS_OFS, stat(2'd3, 3'd0));
        sysval = 8'h60;
      end
      mst = $random(seed);
      src = 1 + ($unsigned($random(seed)) % 7);
      bus(1'b1, LPMC_IRQ_EN_OFS, {23'h0, mst, 8'h01 << src});
      cpu_halt_pc <= $random(seed);
      irq_latch_clear <= $random(seed);
      s0 = svc;
      bus(1'b1, LPMC_SYS_CTRL_OFS, {24'h0, sysval | 8'h10});
      chk({cpu_clk_en, wdt_clk_en, periph_clk_en, state_hold}, 32'h3);
      chk(resume_pc, cpu_halt_pc + 16'h2);
      rdchk(LPMC_STATUS_OFS, stat(sysval[5] ? 2'd3 : 2'd0, sysval[5] ? 3'd2 : 3'd1));
      irq_latch <= 8'h01 << src;
      wait_wake(6);
      chk(svc - s0, {31'h0, mst});
      irq_latch <= 8'h00;
      rdchk(LPMC_SYS_CTRL_OFS, {24'h0, sysval});
    end
    // first pass is slow with timebase off, second fast with the and-term at one
    for (i = 0; i < 2; i++) begin
      src = $unsigned($random(seed)) % 8;
      bus(1'b1, LPMC_TB_CTRL_OFS, {28'h0, i[0], src[2:0]});
      bus(1'b1, LPMC_IRQ_EN_OFS, 32'h140);
      s0 = svc;
      s1 = setc;
      bus(1'b1, LPMC_SYS_CTRL_OFS, {24'h0, sysval | 8'h04});
      chk({cpu_clk_en, periph_clk_en, timebase_clk_en, state_hold}, 32'h3);
      rdchk(LPMC_STATUS_OFS, stat(i ? 2'd0 : 2'd3, i ? 3'd3 : 3'd4));
      timebase_sources <= ~(8'h01 << src);
      wait_wake(8);
      chk(setc - s1, i);
      chk(svc - s0, i);
      rdchk(LPMC_SYS_CTRL_OFS, {24'h0, sysval});
      timebase_sources <= 8'hff;
      rst_pulse();
    end
    irq_latch <= 8'h01;
    bus(1'b1, LPMC_IRQ_EN_OFS, 32'h001);
    bus(1'b1, LPMC_SYS_CTRL_OFS, 32'h90);
    chk({31'h0, cpu_clk_en}, 32'h1);
    irq_latch <= 8'h00;
    bus(1'b1, LPMC_IRQ_EN_OFS, 32'h004);
    bus(1'b1, LPMC_SYS_CTRL_OFS, 32'h90);
    chk({31'h0, cpu_clk_en}, 32'h0);
    // a frozen block must not wake until the enable returns
    clk_en <= 1'b0;
    irq_latch <= 8'h04;
    repeat (4) @(posedge mclk);
    chk({31'h0, cpu_clk_en}, 32'h0);
    clk_en <= 1'b1;
    wait_wake(6);
    irq_latch <= 8'h00;
    bus(1'b1, LPMC_SYS_CTRL_OFS, 32'h90);
    chk({31'h0, cpu_clk_en}, 32'h0);
    reset_pin_n <= 1'b0;
    repeat (4) @(posedge mclk);
    reset_pin_n <= 1'b1;
    repeat (4) @(posedge mclk);
    chk({31'h0, cpu_clk_en}, 32'h1);
    rdchk(LPMC_SYS_CTRL_OFS, {24'h0, LPMC_SYS_CTRL_RST});
    rdchk(LPMC_IRQ_EN_OFS, 32'h0);
    chk(flt, 0);
    for (i = 0; i < 3; i++) begin
      s0 = flt;
      bus(1'b1, LPMC_SYS_CTRL_OFS, {24'h0, bad[i]});
      repeat (2) @(posedge mclk);
      chk(flt - s0, 1);
      rst_pulse();
    end
    bus(1'b1, LPMC_SYS_CTRL_OFS, 32'h94);
    chk({31'h0, cpu_clk_en}, 32'h1);
    results();
  end
endmodule
